// ===== verilog/eccaw_top.v
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "eccaw_defs.vh"

module eccaw_top #(
  parameter AUTO_CORR = 1
) (
  clock,
  rst_b,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  rd_valid,
  rd_addr,
  rd_data,
  rd_sbe,
  rd_dbe,
  cmdq_used,
  wdf_space,
  hmi_irq,
  host_wr_valid,
  host_wr_addr,
  host_wr_be,
  wb_valid,
  wb_addr,
  wb_data,
  wb_check,
  reread_valid,
  reread_addr,
  ecc_irq
);
  input  wire                       clock;
  input  wire                       rst_b;
  input  wire [7:0]                 reg_addr;
  input  wire [31:0]                reg_wdata;
  input  wire                       reg_wr;
  input  wire                       reg_rd;
  output reg  [31:0]                reg_rdata;
  input  wire                       rd_valid;
  input  wire [`ECCAW_ADDR_W-1:0]   rd_addr;
  input  wire [`ECCAW_DATA_W-1:0]   rd_data;
  input  wire                       rd_sbe;
  input  wire                       rd_dbe;
  input  wire [3:0]                 cmdq_used;
  input  wire                       wdf_space;
  input  wire                       hmi_irq;
  input  wire                       host_wr_valid;
  input  wire [`ECCAW_ADDR_W-1:0]   host_wr_addr;
  input  wire [`ECCAW_BE_W-1:0]     host_wr_be;
  output reg                        wb_valid;
  output reg  [`ECCAW_ADDR_W-1:0]   wb_addr;
  output reg  [`ECCAW_DATA_W-1:0]   wb_data;
  output reg  [`ECCAW_CHK_W-1:0]    wb_check;
  output reg                        reread_valid;
  output reg  [`ECCAW_ADDR_W-1:0]   reread_addr;
  output wire                       ecc_irq;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helper

  function addr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  reg  [6:0]                cfg;
  reg                       sts_intr;
  reg                       sts_sbe;
  reg                       sts_dbe;
  reg                       sts_drop;
  reg  [3:0]                cnt_sbe;
  reg  [3:0]                cnt_dbe;
  reg  [3:0]                cnt_drop;
  reg  [`ECCAW_ADDR_W-1:0]  err_addr;
  reg  [`ECCAW_ADDR_W-1:0]  drop_addr;

  reg  [6:0]                next_cfg;
  reg  [31:0]               next_rdata;
  reg  [`ECCAW_DATA_W-1:0]  next_wb_data;

  wire [`ECCAW_CHK_W-1:0]   fresh_check;
  wire                      cfg_wr;
  wire                      clr;
  wire                      sbe_ev;
  wire                      dbe_ev;
  wire                      wb_room;
  wire                      wb_go;
  wire                      drop_ev;
  wire                      intr_ev;
  wire                      retry_ev;
  wire                      auto_on;

  ////////////////////////////////////////////////////////////////////////////
  // Event classification

  assign auto_on = (AUTO_CORR != 0);

  // Double-bit wins when both flags arrive: it cannot be repaired
  assign dbe_ev = rd_valid & rd_dbe;
  assign sbe_ev = rd_valid & rd_sbe & ~rd_dbe;

  // No stalling: a correction lacking room is simply dropped
  assign wb_room = (cmdq_used < `ECCAW_CMDQ_DEPTH) & wdf_space;
  // Every single-bit read that finds room is corrected afresh, dropped before or not
  assign wb_go   = auto_on & sbe_ev & wb_room;
  assign drop_ev = auto_on & sbe_ev & ~wb_room;

  assign intr_ev = (sbe_ev  & ~cfg[`ECCAW_CFG_MASK_SBE])
                 | (dbe_ev  & ~cfg[`ECCAW_CFG_MASK_DBE])
                 | (drop_ev & ~cfg[`ECCAW_CFG_MASK_DROP])
                 | (hmi_irq & ~cfg[`ECCAW_CFG_MASK_HMI]);

  // A write with every byte lane off only forces the location to be read
  assign retry_ev = host_wr_valid & (host_wr_be == {`ECCAW_BE_W{1'b0}});

  assign cfg_wr = reg_wr & addr_hit(reg_addr, `ECCAW_CFG_OFS);
  assign clr    = cfg_wr & reg_wdata[`ECCAW_CFG_CLR];

  assign ecc_irq = sts_intr & cfg[`ECCAW_CFG_EN_INTR];

  ////////////////////////////////////////////////////////////////////////////
  // Write-back data path

  eccaw_check_gen u_check_gen (
    .data  (rd_data),
    .check (fresh_check)
  );

  // Injection flips data after the code is computed, so reads will flag it
  always @* begin
    next_wb_data = rd_data;
    if (cfg[`ECCAW_CFG_GEN_DBE]) begin
      next_wb_data[1:0] = ~rd_data[1:0];
    end else if (cfg[`ECCAW_CFG_GEN_SBE]) begin
      next_wb_data[0] = ~rd_data[0];
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wb_valid <= 1'b0;
      wb_addr  <= {`ECCAW_ADDR_W{1'b0}};
      wb_data  <= {`ECCAW_DATA_W{1'b0}};
      wb_check <= {`ECCAW_CHK_W{1'b0}};
    end else begin
      wb_valid <= wb_go;
      if (wb_go) begin
        wb_addr  <= rd_addr;
        wb_data  <= next_wb_data;
        wb_check <= fresh_check;
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reread_valid <= 1'b0;
      reread_addr  <= {`ECCAW_ADDR_W{1'b0}};
    end else begin
      reread_valid <= retry_ev;
      if (retry_ev) begin
        reread_addr <= host_wr_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration; the clear bit is a pulse and never stored

  always @* begin
    next_cfg = cfg;
    if (cfg_wr) begin
      next_cfg = reg_wdata[6:0];
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= `ECCAW_CFG_RST;
    end else begin
      cfg <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status; a set in the clearing cycle wins over the clear

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sts_intr <= 1'b0;
      sts_sbe  <= 1'b0;
      sts_dbe  <= 1'b0;
      sts_drop <= 1'b0;
    end else begin
      if (intr_ev) begin
        sts_intr <= 1'b1;
      end else if (clr) begin
        sts_intr <= 1'b0;
      end
      if (sbe_ev) begin
        sts_sbe <= 1'b1;
      end else if (clr) begin
        sts_sbe <= 1'b0;
      end
      if (dbe_ev) begin
        sts_dbe <= 1'b1;
      end else if (clr) begin
        sts_dbe <= 1'b0;
      end
      if (drop_ev) begin
        sts_drop <= 1'b1;
      end else if (clr) begin
        sts_drop <= 1'b0;
      end
    end
  end

  // Counters wrap by design and survive the clear bit
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_sbe  <= 4'h0;
      cnt_dbe  <= 4'h0;
      cnt_drop <= 4'h0;
    end else begin
      if (sbe_ev) begin
        cnt_sbe <= cnt_sbe + 4'h1;
      end
      if (dbe_ev) begin
        cnt_dbe <= cnt_dbe + 4'h1;
      end
      if (drop_ev) begin
        cnt_drop <= cnt_drop + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Captured addresses; low word and extension share one register

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_addr  <= {`ECCAW_ADDR_W{1'b0}};
      drop_addr <= {`ECCAW_ADDR_W{1'b0}};
    end else begin
      if (sbe_ev | dbe_ev) begin
        err_addr <= rd_addr;
      end else if (clr) begin
        err_addr <= {`ECCAW_ADDR_W{1'b0}};
      end
      if (drop_ev) begin
        drop_addr <= rd_addr;
      end else if (clr) begin
        drop_addr <= {`ECCAW_ADDR_W{1'b0}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read; data stands one cycle after the strobe, zero otherwise

  always @* begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      if (addr_hit(reg_addr, `ECCAW_CFG_OFS)) begin
        next_rdata[6:0] = cfg;
      end else if (addr_hit(reg_addr, `ECCAW_STS_OFS)) begin
        next_rdata[`ECCAW_STS_INTR] = sts_intr;
        next_rdata[`ECCAW_STS_SBE]  = sts_sbe;
        next_rdata[`ECCAW_STS_DBE]  = sts_dbe;
        next_rdata[`ECCAW_STS_DROP] = sts_drop;
        next_rdata[`ECCAW_STS_SBE_CNT_LO+3:`ECCAW_STS_SBE_CNT_LO] = cnt_sbe;
        next_rdata[`ECCAW_STS_DBE_CNT_LO+3:`ECCAW_STS_DBE_CNT_LO] = cnt_dbe;
        next_rdata[`ECCAW_STS_DRP_CNT_LO+3:`ECCAW_STS_DRP_CNT_LO] = cnt_drop;
      end else if (addr_hit(reg_addr, `ECCAW_ERR_ADDR_OFS)) begin
        next_rdata = err_addr[31:0];
      end else if (addr_hit(reg_addr, `ECCAW_DROP_ADDR_OFS)) begin
        next_rdata = drop_addr[31:0];
      end else if (addr_hit(reg_addr, `ECCAW_ERR_EXT_OFS)) begin
        next_rdata[2:0] = err_addr[34:32];
      end else if (addr_hit(reg_addr, `ECCAW_DROP_EXT_OFS)) begin
        next_rdata[2:0] = drop_addr[34:32];
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

// ===== include/eccaw_defs.vh
`ifndef ECCAW_DEFS_VH
`define ECCAW_DEFS_VH

// Register offsets on the plain register port (word index)
`define ECCAW_CFG_OFS        8'h82
`define ECCAW_STS_OFS        8'h90
`define ECCAW_ERR_ADDR_OFS   8'h91
`define ECCAW_DROP_ADDR_OFS  8'h92
`define ECCAW_ERR_EXT_OFS    8'h93
`define ECCAW_DROP_EXT_OFS   8'h94

// Configuration register fields
`define ECCAW_CFG_GEN_SBE    0
`define ECCAW_CFG_GEN_DBE    1
`define ECCAW_CFG_EN_INTR    2
`define ECCAW_CFG_MASK_SBE   3
`define ECCAW_CFG_MASK_DBE   4
`define ECCAW_CFG_MASK_DROP  5
`define ECCAW_CFG_MASK_HMI   6
`define ECCAW_CFG_CLR        7
`define ECCAW_CFG_RST        7'h00

// Status register fields
`define ECCAW_STS_INTR       0
`define ECCAW_STS_SBE        1
`define ECCAW_STS_DBE        2
`define ECCAW_STS_DROP       3
`define ECCAW_STS_SBE_CNT_LO 4
`define ECCAW_STS_DBE_CNT_LO 8
`define ECCAW_STS_DRP_CNT_LO 12

// Write-back resources
`define ECCAW_CMDQ_DEPTH     4'h8

// Widths
`define ECCAW_DATA_W         64
`define ECCAW_CHK_W          8
`define ECCAW_ADDR_W         35
`define ECCAW_BE_W           8

`endif

// ===== verilog/eccaw_check_gen.v
`timescale 1ns/1ps
`include "eccaw_defs.vh"

module eccaw_check_gen (
  data,
  check
);
  input  wire [`ECCAW_DATA_W-1:0] data;
  output reg  [`ECCAW_CHK_W-1:0]  check;

  integer i;
  integer k;
  integer pos;

  // Hamming positions skip powers of two; bit 7 is overall parity (SECDED)
  always @* begin
    check = 8'h00;
    pos   = 2;
    for (i = 0; i < `ECCAW_DATA_W; i = i + 1) begin
      pos = pos + 1;
      if ((pos & (pos - 1)) == 0) begin
        pos = pos + 1;
      end
      for (k = 0; k < `ECCAW_CHK_W - 1; k = k + 1) begin
        if (((pos >> k) & 1) == 1) begin
          check[k] = check[k] ^ data[i];
        end
      end
    end
    check[`ECCAW_CHK_W-1] = (^data) ^ (^check[`ECCAW_CHK_W-2:0]);
  end

endmodule

// ===== verification/eccaw_mem_model.sv
`timescale 1ns/1ps
// Memory side: returns one read beat per request or per re-read
module eccaw_mem_model (
  input  wire        clock,
  input  wire [1:0]  req,
  input  wire [34:0] req_addr,
  input  wire        full,
  input  wire        nospace,
  input  wire        reread_valid,
  input  wire [34:0] reread_addr,
  output wire        rd_valid,
  output wire [34:0] rd_addr,
  output wire [63:0] rd_data,
  output wire        rd_sbe,
  output wire        rd_dbe,
  output wire [3:0]  cmdq_used,
  output wire        wdf_space
);
  reg  [1:0]  kind = 2'h0;
  reg  [34:0] addr = 35'h0;
  wire [63:0] beat = {addr[31:0], ~addr[31:0]};
  always @(posedge clock) begin
    if (reread_valid) begin
      // The cell was never rewritten, so its single-bit fault is still there
      kind <= 2'h1;
      addr <= reread_addr;
    end else begin
      kind <= req;
      addr <= req_addr;
    end
  end
  assign rd_valid = kind != 2'h0;
  assign rd_sbe = kind == 2'h1;
  assign rd_dbe = kind == 2'h2;
  // Idle beats show inverted values so stale data cannot pass
  assign rd_addr = rd_valid ? addr : ~addr;
  assign rd_data = rd_valid ? beat : ~beat;
  assign cmdq_used = full ? 4'h8 : 4'h3;
  assign wdf_space = !nospace;
endmodule

// ===== verification/eccaw_asserts.sv
`timescale 1ns/1ps
`include "eccaw_defs.vh"
module eccaw_chk #(
  parameter AUTO_CORR = 1
) (
  input wire                    clock,
  input wire                    rst_b,
  input wire [7:0]              reg_addr,
  input wire                    reg_wr,
  input wire                    reg_rd,
  input wire [31:0]             reg_rdata,
  input wire                    rd_valid,
  input wire [`ECCAW_ADDR_W-1:0] rd_addr,
  input wire                    rd_sbe,
  input wire                    rd_dbe,
  input wire [3:0]              cmdq_used,
  input wire                    wdf_space,
  input wire                    host_wr_valid,
  input wire [`ECCAW_ADDR_W-1:0] host_wr_addr,
  input wire [7:0]              host_wr_be,
  input wire                    wb_valid,
  input wire [`ECCAW_ADDR_W-1:0] wb_addr,
  input wire                    reread_valid,
  input wire [`ECCAW_ADDR_W-1:0] reread_addr,
  input wire                    ecc_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire room = (cmdq_used < 4'h8) && wdf_space;
  wire fix = rd_valid && rd_sbe && !rd_dbe && room && (AUTO_CORR != 0);
  wire retry = host_wr_valid && (host_wr_be == 8'h00);
  a_wb_issue: assert property (fix |=> wb_valid && wb_addr == $past(rd_addr))
    else $error("write-back missing");
  a_wb_cause: assert property (!fix |=> !wb_valid)
    else $error("write-back without room or cause");
  a_retry_issue: assert property (retry |=> reread_valid && reread_addr == $past(host_wr_addr))
    else $error("retry re-read missing");
  a_retry_cause: assert property (!retry |=> !reread_valid)
    else $error("re-read without retry");
  a_ext_width: assert property (reg_rd && reg_addr inside {8'h93, 8'h94} |=> reg_rdata[31:3] == 29'h0)
    else $error("extension register too wide");
  a_cfg_self: assert property (reg_rd && reg_addr == 8'h82 |=> reg_rdata[31:7] == 25'h0)
    else $error("clear bit did not self-clear");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_irq_fall: assert property ($fell(ecc_irq) |-> $past(reg_wr) && $past(reg_addr) == 8'h82)
    else $error("interrupt dropped without config write");
  a_wb_held: assert property ($changed(wb_addr) |-> wb_valid)
    else $error("write-back address moved");
  cover property (rd_valid && rd_sbe && !room);
  cover property (retry);
  cover property (wb_valid);
endmodule
bind eccaw_top eccaw_chk #(.AUTO_CORR(AUTO_CORR)) u_chk (.clock, .rst_b, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .rd_valid, .rd_addr, .rd_sbe, .rd_dbe, .cmdq_used, .wdf_space,
  .host_wr_valid, .host_wr_addr, .host_wr_be, .wb_valid, .wb_addr, .reread_valid,
  .reread_addr, .ecc_irq);

// ===== verification/eccaw_tb.sv
`timescale 1ns/1ps
`include "eccaw_defs.vh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module testbench;
  reg         clock = 1'b0;
  reg         rst_b = 1'b0;
  reg  [7:0]  reg_addr = 8'h0;
  reg  [31:0] reg_wdata = 32'h0;
  reg         reg_wr = 1'b0, reg_rd = 1'b0, hmi_irq = 1'b0, host_wr_valid = 1'b0;
  reg         full = 1'b0, nospace = 1'b0;
  reg  [34:0] host_wr_addr = 35'h0, req_addr = 35'h0;
  reg  [7:0]  host_wr_be = 8'h0;
  reg  [1:0]  req = 2'h0;
  wire [31:0] reg_rdata;
  wire [34:0] rd_addr, wb_addr, reread_addr;
  wire [63:0] rd_data, wb_data;
  wire [7:0]  wb_check;
  wire [3:0]  cmdq_used;
  wire        rd_valid, rd_sbe, rd_dbe, wdf_space, wb_valid, reread_valid, ecc_irq;
  int         err_total = 0, checked = 0, wbs = 0;
  reg  [7:0]  ofs [0:6] = '{8'h82, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h10};
  eccaw_top uut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rd_valid, .rd_addr, .rd_data, .rd_sbe, .rd_dbe, .cmdq_used, .wdf_space, .hmi_irq,
    .host_wr_valid, .host_wr_addr, .host_wr_be, .wb_valid, .wb_addr, .wb_data,
    .wb_check, .reread_valid, .reread_addr, .ecc_irq);
  eccaw_mem_model mem (.clock, .req, .req_addr, .full, .nospace, .reread_valid,
    .reread_addr, .rd_valid, .rd_addr, .rd_data, .rd_sbe, .rd_dbe, .cmdq_used, .wdf_space);
  always #25 clock = ~clock;
  always @(posedge clock) if (wb_valid === 1'b1) wbs <= wbs + 1;
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask
  // Kind 1 is a single-bit beat, 2 a double-bit beat
  task beat(input [1:0] k, input [34:0] a);
    @(posedge clock);
    {req, req_addr} <= {k, a};
    @(posedge clock);
    req <= 2'h0;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task hostwr(input [34:0] a, input [7:0] be);
    @(posedge clock);
    {host_wr_valid, host_wr_addr, host_wr_be} <= {1'b1, a, be};
    @(posedge clock);
    host_wr_valid <= 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask
  // Reference code: data fills the non-power positions 3,5,6,7,9.. in order
  function automatic [7:0] secded(input [63:0] d);
    int i;
    secded = 8'h00;
    i = 0;
    for (int p = 3; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int k = 0; k < 7; k++) if (p[k]) secded[k] ^= d[i];
        i++;
      end
    end
    secded[7] = ^{d, secded[6:0]};
  endfunction
  // The check code always covers the clean data, never the injected flips
  task wbchk(input int n, input [34:0] a, input [1:0] flip = 2'h0);
    `CHK("wb count", n, wbs)
    `CHK("wb_addr", a, wb_addr)
    `CHK("wb_data", {a[31:0], ~a[31:0]} ^ flip, wb_data)
    `CHK("wb_check", secded({a[31:0], ~a[31:0]}), wb_check)
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge clock);
    err_total++;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    wr(8'h92, 32'hFFFF_FFFF);
    for (int i = 0; i < 7; i++) rd(ofs[i], 32'h0);
    $display("test reset done");
    wr(8'h82, 32'h04);
    rd(8'h82, 32'h04);
    beat(2'h1, 35'h5_1234_5678);
    wbchk(1, 35'h5_1234_5678);
    rd(8'h90, 32'h13);
    rd(8'h91, 32'h1234_5678);
    rd(8'h93, 32'h5);
    `CHK("ecc_irq", 1'b1, ecc_irq)
    beat(2'h2, 35'h2_0000_00A0);
    `CHK("wb count", 1, wbs)
    rd(8'h90, 32'h117);
    rd(8'h91, 32'hA0);
    rd(8'h93, 32'h2);
    $display("test errors done");
    wr(8'h82, 32'h84);
    rd(8'h82, 32'h04);
    rd(8'h90, 32'h110);
    rd(8'h91, 32'h0);
    rd(8'h93, 32'h0);
    `CHK("ecc_irq", 1'b0, ecc_irq)
    $display("test clear done");
    @(posedge clock) full <= 1'b1;
    beat(2'h1, 35'h7_CAFE_0000);
    `CHK("wb count", 1, wbs)
    rd(8'h90, 32'h112B);
    rd(8'h92, 32'hCAFE_0000);
    rd(8'h94, 32'h7);
    @(posedge clock) {full, nospace} <= 2'b01;
    beat(2'h1, 35'h3_0000_0044);
    rd(8'h90, 32'h213B);
    rd(8'h92, 32'h44);
    rd(8'h94, 32'h3);
    @(posedge clock) nospace <= 1'b0;
    $display("test drop done");
    hostwr(35'h3_0000_0044, 8'h01);
    `CHK("wb count", 1, wbs)
    hostwr(35'h3_0000_0044, 8'h00);
    wbchk(2, 35'h3_0000_0044);
    $display("test retry done");
    wr(8'h82, 32'h8C);
    beat(2'h1, 35'h5_1234_5678);
    wbchk(3, 35'h5_1234_5678);
    rd(8'h90, 32'h2152);
    `CHK("ecc_irq", 1'b0, ecc_irq)
    @(posedge clock) hmi_irq <= 1'b1;
    @(posedge clock) hmi_irq <= 1'b0;
    rd(8'h90, 32'h2153);
    `CHK("ecc_irq", 1'b1, ecc_irq)
    $display("test mask done");
    wr(8'h82, 32'h01);
    beat(2'h1, 35'h1_0F0F_0F0F);
    wbchk(4, 35'h1_0F0F_0F0F, 2'h1);
    wr(8'h82, 32'h03);
    beat(2'h1, 35'h6_8000_0001);
    wbchk(5, 35'h6_8000_0001, 2'h3);
    $display("test inject done");
    // Every event source masked: flags and counts move, the interrupt does not
    wr(8'h82, 32'hFC);
    @(posedge clock) full <= 1'b1;
    beat(2'h1, 35'h4_0000_0F00);
    beat(2'h2, 35'h2_0000_0B00);
    @(posedge clock) {full, hmi_irq} <= 2'b01;
    @(posedge clock) hmi_irq <= 1'b0;
    rd(8'h90, 32'h328E);
    rd(8'h92, 32'h0F00);
    rd(8'h94, 32'h4);
    `CHK("ecc_irq", 1'b0, ecc_irq)
    `CHK("wb count", 5, wbs)
    $display("test masked drop done");
    conclude;
  end
endmodule
